// ==== rtl/tbc_pkg.sv ====
package tbc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TBC_CTRL_OFFSET = 8'h0C;
  localparam logic [7:0] TBC_CTRL_RESET = 8'h75;
  localparam int TBC_COOL_ISET_MSB = 7;
  localparam int TBC_COOL_ISET_LSB = 6;
  localparam int TBC_WARM_ISET_MSB = 5;
  localparam int TBC_WARM_ISET_LSB = 4;
  localparam int TBC_COOL_VT_MSB = 3;
  localparam int TBC_COOL_VT_LSB = 2;
  localparam int TBC_WARM_VT_MSB = 1;
  localparam int TBC_WARM_VT_LSB = 0;

  // ----------------------------------------------------------------
  // Current scale codes and their percentages
  // ----------------------------------------------------------------
  localparam logic [1:0] TBC_ISET_NONE = 2'h0;
  localparam logic [1:0] TBC_ISET_FULL = 2'h3;
  localparam logic [6:0] TBC_PCT_NONE = 7'h00;
  localparam logic [6:0] TBC_PCT_20 = 7'h14;
  localparam logic [6:0] TBC_PCT_50 = 7'h32;
  localparam logic [6:0] TBC_PCT_100 = 7'h64;

  // ----------------------------------------------------------------
  // Boundary ratios in hundredths of a percent
  // ----------------------------------------------------------------
  localparam logic [13:0] TBC_VT2_C0 = 14'h1BA3;
  localparam logic [13:0] TBC_VT2_C1 = 14'h1AA9;
  localparam logic [13:0] TBC_VT2_C2 = 14'h197D;
  localparam logic [13:0] TBC_VT2_C3 = 14'h1851;
  localparam logic [13:0] TBC_VT3_C0 = 14'h12D9;
  localparam logic [13:0] TBC_VT3_C1 = 14'h117B;
  localparam logic [13:0] TBC_VT3_C2 = 14'h0FEB;
  localparam logic [13:0] TBC_VT3_C3 = 14'h0EBF;

  typedef enum logic [1:0] {
    TBC_BAND_NORMAL,
    TBC_BAND_COOL,
    TBC_BAND_WARM
  } tbc_band_type;
endpackage

// ==== rtl/tbc_thermal_charge_profile_regs.sv ====
`timescale 1ns/1ps
// Operation
// - 8-bit RW register at 0Ch, reset 75h
// - Bits 7:6 scale current in cool band
// - Bits 5:4 scale current in warm band
// - Full current code disables timer doubling
// - Bits 3:2 select cool boundary ratio
// - Bits 1:0 select warm boundary ratio
// - Register-reset bit restores defaults, self-clears
// - Watchdog expiry restores defaults, flags expiry
module tbc_thermal_charge_profile_regs
  import tbc_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RESET_REQ_I,
  input wire logic WATCHDOG_EXPIRED_I,
  input wire logic BAND_EVAL_I,
  input wire logic COOL_BAND_I,
  input wire logic WARM_BAND_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RESET_BUSY_O,
  output logic SAFETY_TIMER_RESTART_O,
  output logic WATCHDOG_FAULT_O,
  output logic [6:0] CHARGE_PCT_O,
  output logic CHARGE_STOP_O,
  output logic TIMER_DOUBLE_O,
  output logic [13:0] COOL_RATIO_O,
  output logic [13:0] WARM_RATIO_O
);

  // ----------------------------------------------------------------
  // Register and reset handling
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic busy;
  logic next_busy;
  logic restart;
  logic next_restart;
  logic hit;

  assign hit = (REG_ADDR_I == TBC_CTRL_OFFSET);

  always_comb begin
    next_ctrl = ctrl;
    next_busy = 1'b0;
    next_restart = 1'b0;
    if (REG_WR_I && hit) begin
      next_ctrl = REG_WDATA_I;
    end
    // Register reset takes one cycle and then reads back as done
    if (REG_RESET_REQ_I) begin
      next_ctrl = TBC_CTRL_RESET;
      next_busy = 1'b1;
      next_restart = 1'b1;
    end
    // Expiry outranks a same-cycle write
    if (WATCHDOG_EXPIRED_I) begin
      next_ctrl = TBC_CTRL_RESET;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      ctrl <= TBC_CTRL_RESET;
      busy <= 1'b0;
      restart <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      busy <= next_busy;
      restart <= next_restart;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog flag
  // ----------------------------------------------------------------
  logic wd_fault;
  logic next_wd_fault;

  always_comb begin
    next_wd_fault = wd_fault;
    // Host leaves default mode by rewriting the register
    if (REG_WR_I && hit) begin
      next_wd_fault = 1'b0;
    end
    // Set wins over a same-cycle clear so no expiry is lost
    if (WATCHDOG_EXPIRED_I) begin
      next_wd_fault = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      wd_fault <= 1'b0;
    end else begin
      wd_fault <= next_wd_fault;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata;
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = rdata;
    if (REG_RD_I) begin
      // Unmapped addresses read as zero rather than stale data
      next_rdata = hit ? ctrl : 8'h00;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Band evaluation
  // ----------------------------------------------------------------
  tbc_band_type band;
  logic [1:0] iset;
  logic [6:0] pct;
  logic [6:0] next_pct;
  logic stop;
  logic next_stop;
  logic dbl;
  logic next_dbl;
  logic [13:0] cool_ratio;
  logic [13:0] next_cool_ratio;
  logic [13:0] warm_ratio;
  logic [13:0] next_warm_ratio;

  always_comb begin
    if (COOL_BAND_I) begin
      band = TBC_BAND_COOL;
    end else if (WARM_BAND_I) begin
      band = TBC_BAND_WARM;
    end else begin
      band = TBC_BAND_NORMAL;
    end
    unique case (band)
      TBC_BAND_COOL: iset = ctrl[TBC_COOL_ISET_MSB:TBC_COOL_ISET_LSB];
      TBC_BAND_WARM: iset = ctrl[TBC_WARM_ISET_MSB:TBC_WARM_ISET_LSB];
      default: iset = TBC_ISET_FULL;
    endcase
  end

  // Outputs follow live register contents at each evaluation strobe
  always_comb begin
    next_pct = pct;
    next_stop = stop;
    next_dbl = dbl;
    next_cool_ratio = cool_ratio;
    next_warm_ratio = warm_ratio;
    if (BAND_EVAL_I) begin
      unique case (iset)
        2'h0: next_pct = TBC_PCT_NONE;
        2'h1: next_pct = TBC_PCT_20;
        2'h2: next_pct = TBC_PCT_50;
        2'h3: next_pct = TBC_PCT_100;
      endcase
      next_stop = (iset == TBC_ISET_NONE);
      // Derated bands double the timer; normal band never does
      next_dbl = (band != TBC_BAND_NORMAL) && (iset != TBC_ISET_FULL);
      unique case (ctrl[TBC_COOL_VT_MSB:TBC_COOL_VT_LSB])
        2'h0: next_cool_ratio = TBC_VT2_C0;
        2'h1: next_cool_ratio = TBC_VT2_C1;
        2'h2: next_cool_ratio = TBC_VT2_C2;
        2'h3: next_cool_ratio = TBC_VT2_C3;
      endcase
      unique case (ctrl[TBC_WARM_VT_MSB:TBC_WARM_VT_LSB])
        2'h0: next_warm_ratio = TBC_VT3_C0;
        2'h1: next_warm_ratio = TBC_VT3_C1;
        2'h2: next_warm_ratio = TBC_VT3_C2;
        2'h3: next_warm_ratio = TBC_VT3_C3;
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      pct <= TBC_PCT_100;
      stop <= 1'b0;
      dbl <= 1'b0;
      cool_ratio <= TBC_VT2_C1;
      warm_ratio <= TBC_VT3_C1;
    end else begin
      pct <= next_pct;
      stop <= next_stop;
      dbl <= next_dbl;
      cool_ratio <= next_cool_ratio;
      warm_ratio <= next_warm_ratio;
    end
  end

  assign REG_RDATA_O = rdata;
  assign REG_RESET_BUSY_O = busy;
  assign SAFETY_TIMER_RESTART_O = restart;
  assign WATCHDOG_FAULT_O = wd_fault;
  assign CHARGE_PCT_O = pct;
  assign CHARGE_STOP_O = stop;
  assign TIMER_DOUBLE_O = dbl;
  assign COOL_RATIO_O = cool_ratio;
  assign WARM_RATIO_O = warm_ratio;

endmodule // tbc_thermal_charge_profile_regs

// ==== sim/tbc_host.sv ====
`timescale 1ns/1ps
module tbc_host (
  input logic c_i,
  output logic [7:0] a_o,
  output logic [7:0] d_o,
  output logic w_o,
  output logic r_o,
  output logic q_o
);
  // ----
  // Parallel register-bus front end, one strobe per access
  // ----
  initial {a_o, d_o, w_o, r_o, q_o} = '0;
  task wr(input logic [7:0] x, y);
    a_o <= x;
    d_o <= y;
    w_o <= 1;
    @(posedge c_i) w_o <= 0;
    // Stale data must not look valid after the strobe
    d_o <= ~y;
  endtask
  task rd(input logic [7:0] x);
    a_o <= x;
    r_o <= 1;
    @(posedge c_i) r_o <= 0;
  endtask
  task rr;
    q_o <= 1;
    @(posedge c_i) q_o <= 0;
  endtask
endmodule // tbc_host

// ==== sim/tbc_checker.sv ====
`timescale 1ns/1ps
module tbc_checker (
  input logic MCLK_I,
  input logic SYS_RST_I,
  input logic [7:0] REG_ADDR_I,
  input logic REG_RD_I,
  input logic REG_RESET_REQ_I,
  input logic WATCHDOG_EXPIRED_I,
  input logic BAND_EVAL_I,
  input logic [7:0] REG_RDATA_O,
  input logic REG_RESET_BUSY_O,
  input logic SAFETY_TIMER_RESTART_O,
  input logic WATCHDOG_FAULT_O,
  input logic [6:0] CHARGE_PCT_O,
  input logic CHARGE_STOP_O,
  input logic TIMER_DOUBLE_O
);
  // ----
  // Checks
  // ----
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_rb; REG_RESET_REQ_I |=> REG_RESET_BUSY_O; endproperty
  property p_tr; REG_RESET_REQ_I |=> SAFETY_TIMER_RESTART_O; endproperty
  property p_bc; REG_RESET_BUSY_O |-> $past(REG_RESET_REQ_I); endproperty
  property p_wd; WATCHDOG_EXPIRED_I |=> WATCHDOG_FAULT_O; endproperty
  property p_rz;
    REG_RD_I && REG_ADDR_I != 8'h0C |=> REG_RDATA_O == 8'h00;
  endproperty
  property p_st; BAND_EVAL_I |=> CHARGE_STOP_O == (CHARGE_PCT_O == 7'h00);
  endproperty
  property p_db; TIMER_DOUBLE_O |-> CHARGE_PCT_O != 7'h64; endproperty
  property p_df;
    (REG_RESET_REQ_I || WATCHDOG_EXPIRED_I) ##1 REG_RD_I &&
      REG_ADDR_I == 8'h0C |=> REG_RDATA_O == 8'h75;
  endproperty
  a_rb: assert property (p_rb) else $error("no busy pulse");
  a_tr: assert property (p_tr) else $error("no timer restart");
  a_bc: assert property (p_bc) else $error("stray busy");
  a_wd: assert property (p_wd) else $error("no fault flag");
  a_rz: assert property (p_rz) else $error("unmapped read");
  a_st: assert property (p_st) else $error("stop vs pct");
  a_db: assert property (p_db) else $error("doubled at full");
  a_df: assert property (p_df) else $error("not default");
  c_rb: cover property (REG_RESET_BUSY_O);
  c_wd: cover property (WATCHDOG_FAULT_O);
  c_db: cover property (TIMER_DOUBLE_O);
endmodule // tbc_checker
bind tbc_thermal_charge_profile_regs tbc_checker tbc_checker_i (.*);

// ==== sim/thermal_charge_profile_regs_test.sv ====
`timescale 1ns/1ps
module thermal_charge_profile_regs_test;
  logic MCLK_I, SYS_RST_I, WATCHDOG_EXPIRED_I, BAND_EVAL_I;
  logic COOL_BAND_I, WARM_BAND_I, REG_WR_I, REG_RD_I, REG_RESET_REQ_I;
  logic REG_RESET_BUSY_O, SAFETY_TIMER_RESTART_O, WATCHDOG_FAULT_O;
  logic CHARGE_STOP_O, TIMER_DOUBLE_O;
  logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O, d, rq[$];
  logic [6:0] CHARGE_PCT_O;
  logic [13:0] COOL_RATIO_O, WARM_RATIO_O;
  logic [36:0] bq[$];
  int fail_count, tests_run, cyc;
  bit pr, pb;
  tbc_thermal_charge_profile_regs tbc_thermal_charge_profile_regs_i (.*);
  tbc_host tbc_host_i (.c_i(MCLK_I), .a_o(REG_ADDR_I), .d_o(REG_WDATA_I),
    .w_o(REG_WR_I), .r_o(REG_RD_I), .q_o(REG_RESET_REQ_I));
  always #5 MCLK_I = ~MCLK_I;
  // ----
  // Expectations and checking
  // ----
  function automatic logic [36:0] band(logic [7:0] v, int b);
    logic [6:0] p[4] = '{7'h00, 7'h14, 7'h32, 7'h64};
    logic [13:0] cr[4] = '{14'h1BA3, 14'h1AA9, 14'h197D, 14'h1851};
    logic [13:0] wr[4] = '{14'h12D9, 14'h117B, 14'h0FEB, 14'h0EBF};
    logic [1:0] k = b == 1 ? v[7:6] : (b == 2 ? v[5:4] : 2'h3);
    return {p[k], k == 2'h0, k != 2'h3, cr[v[3:2]], wr[v[1:0]]};
  endfunction
  task chk_band(logic [36:0] g, e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task chk_rd(logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task chk_flag(logic g, e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task stop_test;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task ev(int b, logic [7:0] v);
    COOL_BAND_I <= b == 1;
    WARM_BAND_I <= b == 2;
    BAND_EVAL_I <= 1;
    bq.push_back(band(v, b));
    @(posedge MCLK_I) BAND_EVAL_I <= 0;
    @(posedge MCLK_I);
  endtask
  always @(negedge MCLK_I) begin
    if (pr) chk_rd(REG_RDATA_O, rq.pop_front());
    if (pb) chk_band({CHARGE_PCT_O, CHARGE_STOP_O, TIMER_DOUBLE_O, COOL_RATIO_O,
      WARM_RATIO_O}, bq.pop_front());
    pr = REG_RD_I;
    pb = BAND_EVAL_I;
  end
  always @(posedge MCLK_I) if (++cyc > 2000) begin
    fail_count++;
    stop_test;
  end
  initial begin
    MCLK_I = 1'b0;
    SYS_RST_I <= 1'b1;
    WATCHDOG_EXPIRED_I <= 1'b0;
    BAND_EVAL_I <= 1'b0;
    COOL_BAND_I <= 1'b0;
    WARM_BAND_I <= 1'b0;
    void'($urandom(80));
    repeat (10) @(posedge MCLK_I);
    SYS_RST_I <= 0;
    rq.push_back(8'h75);
    tbc_host_i.rd(8'h0C);
    $display("reset value done");
    for (int i = 0; i < 16; i++) begin
      d = i < 4 ? {4{i[1:0]}} : 8'($urandom);
      tbc_host_i.wr(8'h0C, d);
      rq.push_back(d);
      tbc_host_i.rd(8'h0C);
      for (int b = 0; b < 3; b++) ev(b, d);
    end
    $display("band codes done");
    tbc_host_i.wr(8'h0D, ~d);
    rq.push_back(8'h00);
    tbc_host_i.rd(8'h0D);
    @(posedge MCLK_I);
    rq.push_back(d);
    tbc_host_i.rd(8'h0C);
    tbc_host_i.rr();
    rq.push_back(8'h75);
    tbc_host_i.rd(8'h0C);
    ev(1, 8'h75);
    $display("register reset done");
    tbc_host_i.wr(8'h0C, 8'h00);
    WATCHDOG_EXPIRED_I <= 1;
    @(posedge MCLK_I) WATCHDOG_EXPIRED_I <= 0;
    rq.push_back(8'h75);
    tbc_host_i.rd(8'h0C);
    #1 chk_flag(WATCHDOG_FAULT_O, 1'b1);
    @(posedge MCLK_I);
    tbc_host_i.wr(8'h0C, d);
    #1 chk_flag(WATCHDOG_FAULT_O, 1'b0);
    $display("watchdog done");
    repeat (3) @(posedge MCLK_I);
    stop_test;
  end
endmodule // thermal_charge_profile_regs_test
